// ---- collect_pkg.sv ----
// Purpose: shared constants and types for the collection and delay counters
// Assumes: one clock domain, register port with word addresses
// Notes: address and delay counts are decimal digits held four bits each; the wrap count is binary
package collect_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h1;
  localparam logic [3:0] ADDR_COUNT_ADDR = 4'h2;

  // ********************************
  // control and status fields
  // ********************************
  localparam int CTRL_HALT_SEL_BIT = 0;
  localparam int CTRL_SW_GATE_N_BIT = 1;
  localparam int CTRL_MAIN_SEL_BIT = 2;
  localparam int CTRL_PRESET_BIT = 3;
  localparam int STAT_WRAP_BIT = 0;
  localparam int STAT_HALT_N_BIT = 1;
  localparam int STAT_TERM_N_BIT = 2;

  // ********************************
  // reset values and counts
  // ********************************
  localparam logic CTRL_HALT_SEL_RST = 1'b0;
  localparam logic CTRL_SW_GATE_N_RST = 1'b1;
  localparam logic CTRL_MAIN_SEL_RST = 1'b1;
  localparam logic [11:0] ADDR_PRESET_BCD = 12'h023;
  localparam logic [9:0] WRAP_LAST_COUNT = 10'h3E7;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] DIGIT_MIN = 4'h0;

  typedef struct packed {
    logic main_sel;
    logic sw_gate_n;
    logic halt_sel;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{main_sel: CTRL_MAIN_SEL_RST, sw_gate_n: CTRL_SW_GATE_N_RST,
                                 halt_sel: CTRL_HALT_SEL_RST};

  typedef struct packed {
    logic strobe_n;
    logic [2:0] step;
    logic [15:0] data;
  } count_ram_wr_t;

endpackage

// ---- collect_counters.sv ----
// Purpose: acquisition address counter, wrap and halt logic, per-step delay counter
// Assumes: all inputs synchronous to mclk, the qualified master clock
// Notes: register port reads answer one cycle after the read strobe
//
// Contract
// (R1) address counter is three cascaded decimal stages, count up, low stage least significant
// (R2) address counter preset to decimal 23 before each collection
// (R3) wrap flag set sticky after 1000 advances unless already halted
// (R4) load_address_n low passes processor address straight to memory address
// (R5) address counter value driven on processor data bus while read enable low
// (R6) wrap flag readable in status and fed to clock gate logic
// (R7) sample clocks gated by wrap flag or software clock gate bit
// (R8) halt select high: wrap or sequencer done halts; low: wrap ignored
// (R9) active low halt stops sampling and reads as collection complete
// (R10) one shared delay counter serves all 8 steps by reloading
// (R11) delay counter is four decimal stages, 0000 through 9999
// (R12) count ram addressed by current sequencer step
// (R13) processor writes delay counts into count ram before collection
// (R14) count ram holds one four digit count per each of 8 steps
// (R15) low stage counts up, upper three down; terminal when all terminal
// (R16) parallel load low loads count presented by count ram
// (R17) processor programs ram via step bus, data bus, write strobe pulse
// (R18) delay counter advances only while count enable high; terminal to sequencer
// (R19) sample recorded only while trace high
// (R20) float control high floats terminal count output
// (R21) main/aux select low routes processor access to auxiliary memory
// (R22) processor asserts load address on every hardware access
// (R23) address advances per clock on trace without halt, else holds
// (R24) delay counter and load clocked synchronously by master clock
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module collect_counters
  import collect_pkg::*;
#(
  parameter int STEPS = 8,
  parameter int STEP_W = 3
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic load_address_n,
  input wire logic [9:0] proc_address,
  input wire logic read_addr_en_n,
  output logic [9:0] proc_data_o,
  output logic proc_data_oe,
  input wire logic trace,
  input wire logic seq_done,
  input wire logic [STEP_W-1:0] step_select_bus,
  input wire logic count_ram_write_n,
  input wire logic [15:0] count_ram_data_bus,
  input wire logic delay_parallel_load_n,
  input wire logic delay_count_enable,
  input wire logic output_float_ctrl,
  output logic delay_terminal_n_o,
  output logic delay_terminal_n_oe,
  output logic [9:0] acq_mem_address,
  output logic sample_write,
  output logic wrap_clock_gate_n,
  output logic translator_clock_gate_n,
  output logic halt_n,
  output logic main_mem_select,
  output logic aux_mem_select
);

  // ********************************
  // helper functions
  // ********************************
  function automatic logic [9:0] bcd_to_bin(input logic [11:0] bcd);
    logic [13:0] sum;
    sum = 14'(bcd[11:8]) * 14'h064 + 14'(bcd[7:4]) * 14'h00A + 14'(bcd[3:0]);
    return sum[9:0];
  endfunction

  function automatic logic [3:0] digit_up(input logic [3:0] d);
    return (d == DIGIT_MAX) ? DIGIT_MIN : 4'(d + 4'h1);
  endfunction

  function automatic logic [3:0] digit_down(input logic [3:0] d);
    return (d == DIGIT_MIN) ? DIGIT_MAX : 4'(d - 4'h1);
  endfunction

  // ********************************
  // state
  // ********************************
  ctrl_t ctrl_reg;
  logic preset_pulse;
  logic [11:0] addr_bcd_reg;
  logic [9:0] adv_count_reg;
  logic wrap_reg;
  logic halt_n_reg;
  logic [9:0] addr_out_reg;
  logic [9:0] proc_data_reg;
  logic [15:0] rdata_reg;
  logic [15:0] delay_reg;
  logic [15:0] count_ram [STEPS];
  count_ram_wr_t ram_wr;
  logic advance;
  logic halt_next;
  logic delay_term;

  assign ram_wr = '{strobe_n: count_ram_write_n, step: step_select_bus, data: count_ram_data_bus};
  assign preset_pulse = reg_wr && (reg_addr == CTRL_ADDR) && reg_wdata[CTRL_PRESET_BIT];

  // ********************************
  // control register
  // ********************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RST;
    end
    else if (reg_wr && (reg_addr == CTRL_ADDR))
    begin
      ctrl_reg.halt_sel <= reg_wdata[CTRL_HALT_SEL_BIT];
      ctrl_reg.sw_gate_n <= reg_wdata[CTRL_SW_GATE_N_BIT];
      ctrl_reg.main_sel <= reg_wdata[CTRL_MAIN_SEL_BIT];
    end
  end

  // ********************************
  // address counter
  // ********************************
  // (R7) sampling gated
  // (R19) trace qualifies
  // (R23) advance or hold
  assign advance = trace && halt_n_reg && !wrap_reg && ctrl_reg.sw_gate_n && load_address_n;
  assign sample_write = advance;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      addr_bcd_reg <= ADDR_PRESET_BCD;
    end
    // (R2) preset to 23
    else if (preset_pulse)
    begin
      addr_bcd_reg <= ADDR_PRESET_BCD;
    end
    // (R1) decimal up cascade
    else if (advance)
    begin
      addr_bcd_reg[3:0] <= digit_up(addr_bcd_reg[3:0]);
      if (addr_bcd_reg[3:0] == DIGIT_MAX)
      begin
        addr_bcd_reg[7:4] <= digit_up(addr_bcd_reg[7:4]);
        if (addr_bcd_reg[7:4] == DIGIT_MAX)
        begin
          addr_bcd_reg[11:8] <= digit_up(addr_bcd_reg[11:8]);
        end
      end
    end
  end

  // ********************************
  // wrap flag
  // ********************************
  // advances counted separately so wrap does not depend on start point
  always_ff @(posedge mclk)
  begin
    if (!rst_n || preset_pulse)
    begin
      adv_count_reg <= '0;
    end
    else if (advance)
    begin
      adv_count_reg <= (adv_count_reg == WRAP_LAST_COUNT) ? '0 : 10'(adv_count_reg + 10'h001);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wrap_reg <= 1'b0;
    end
    // (R3) sticky wrap
    // set beats preset so a recorded 1000th sample is never lost
    else if (advance && adv_count_reg == WRAP_LAST_COUNT)
    begin
      wrap_reg <= 1'b1;
    end
    else if (preset_pulse)
    begin
      wrap_reg <= 1'b0;
    end
  end

  // ********************************
  // halt
  // ********************************
  // (R8) halt source select
  assign halt_next = seq_done || (ctrl_reg.halt_sel && wrap_reg);

  always_ff @(posedge mclk)
  begin
    if (!rst_n || preset_pulse)
    begin
      halt_n_reg <= 1'b1;
    end
    // (R9) halt stays until next preset
    else if (halt_next)
    begin
      halt_n_reg <= 1'b0;
    end
  end

  assign halt_n = halt_n_reg;
  // (R6) wrap to clock gates
  assign wrap_clock_gate_n = !wrap_reg;
  // (R7) software gate too
  assign translator_clock_gate_n = !wrap_reg && ctrl_reg.sw_gate_n;

  // ********************************
  // memory address and readback
  // ********************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      addr_out_reg <= '0;
      proc_data_reg <= '0;
    end
    else
    begin
      // (R4) processor address through
      addr_out_reg <= load_address_n ? bcd_to_bin(addr_bcd_reg) : proc_address;
      // (R5) counter onto data bus
      proc_data_reg <= bcd_to_bin(addr_bcd_reg);
    end
  end

  assign acq_mem_address = addr_out_reg;
  assign proc_data_o = proc_data_reg;
  assign proc_data_oe = !read_addr_en_n;

  // (R21) main or auxiliary memory
  assign main_mem_select = ctrl_reg.main_sel;
  assign aux_mem_select = !ctrl_reg.main_sel;

  // ********************************
  // count ram
  // ********************************
  // no reset on the array; contents are defined only after programming
  // (R14) one count per step
  // (R17) strobe writes step entry
  always_ff @(posedge mclk)
  begin
    if (!ram_wr.strobe_n)
    begin
      count_ram[ram_wr.step] <= ram_wr.data;
    end
  end

  // ********************************
  // delay counter
  // ********************************
  // (R15) all stages terminal
  assign delay_term = (delay_reg[3:0] == DIGIT_MAX) && (delay_reg[7:4] == DIGIT_MIN)
    && (delay_reg[11:8] == DIGIT_MIN) && (delay_reg[15:12] == DIGIT_MIN);

  // (R24) synchronous load and count
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      delay_reg <= DELAY_RST;
    end
    // (R10) shared counter reloaded
    // (R12) step selects count
    // (R16) parallel load
    else if (!delay_parallel_load_n)
    begin
      delay_reg <= count_ram[step_select_bus];
    end
    // (R18) count enable gates
    // (R11) four decimal stages
    else if (delay_count_enable)
    begin
      delay_reg[3:0] <= digit_up(delay_reg[3:0]);
      if (delay_reg[3:0] == DIGIT_MAX)
      begin
        delay_reg[7:4] <= digit_down(delay_reg[7:4]);
        if (delay_reg[7:4] == DIGIT_MIN)
        begin
          delay_reg[11:8] <= digit_down(delay_reg[11:8]);
          if (delay_reg[11:8] == DIGIT_MIN)
          begin
            delay_reg[15:12] <= digit_down(delay_reg[15:12]);
          end
        end
      end
    end
  end

  // (R18) terminal to sequencer
  assign delay_terminal_n_o = !delay_term;
  // (R20) float terminal output
  assign delay_terminal_n_oe = !output_float_ctrl;

  // ********************************
  // register read port
  // ********************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        CTRL_ADDR: rdata_reg <= {13'h0, ctrl_reg.main_sel, ctrl_reg.sw_gate_n, ctrl_reg.halt_sel};
        // (R6) wrap in status
        // (R9) halt as complete
        STATUS_ADDR: rdata_reg <= {13'h0, !delay_term, halt_n_reg, wrap_reg};
        ADDR_COUNT_ADDR: rdata_reg <= {6'h0, bcd_to_bin(addr_bcd_reg)};
        default: rdata_reg <= '0;
      endcase
    end
    else
    begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// ---- collect_counters_properties.sv ----
// Purpose: port checks for the collection and delay counters
// Assumes: one clock, synchronous active-low reset
// Notes: halt select is not visible here, so wrap-to-halt is judged by the bench
`timescale 1ns/1ns
module collect_counters_properties
  import collect_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic load_address_n,
  input wire logic [9:0] proc_address,
  input wire logic [9:0] acq_mem_address,
  input wire logic read_addr_en_n,
  input wire logic proc_data_oe,
  input wire logic output_float_ctrl,
  input wire logic delay_terminal_n_oe,
  input wire logic trace,
  input wire logic seq_done,
  input wire logic halt_n,
  input wire logic sample_write,
  input wire logic wrap_clock_gate_n,
  input wire logic translator_clock_gate_n
);
  // ****************
  // checks
  // ****************
  logic preset;
  // preset clears both sticky flags, so it excuses them
  assign preset = reg_wr && reg_addr == CTRL_ADDR && reg_wdata[CTRL_PRESET_BIT];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  pass_thru_a: assert property (!load_address_n |=> acq_mem_address == $past(proc_address))
    else $error("memory address missed processor address");
  read_oe_a: assert property (proc_data_oe == !read_addr_en_n)
    else $error("data bus enable wrong");
  float_a: assert property (delay_terminal_n_oe == !output_float_ctrl)
    else $error("terminal float wrong");
  gate_pair_a: assert property (!wrap_clock_gate_n |-> !translator_clock_gate_n)
    else $error("translator gate open on wrap");
  sample_gate_a: assert property (sample_write == (trace && halt_n && load_address_n && translator_clock_gate_n))
    else $error("sample write gating wrong");
  halt_done_a: assert property (seq_done && !preset |=> !halt_n)
    else $error("no halt after done");
  halt_hold_a: assert property (!halt_n && !preset |=> !halt_n)
    else $error("halt released");
  wrap_hold_a: assert property (!wrap_clock_gate_n && !preset |=> $stable(wrap_clock_gate_n))
    else $error("wrap released");
  cover property ($fell(halt_n));
  cover property ($fell(wrap_clock_gate_n));
  cover property (!load_address_n ##1 !load_address_n);
endmodule

// ---- seq_model.sv ----
// Purpose: sequencer and count loader on the far side
// Assumes: bench calls one task at a time
// Notes: released data bus shows the inverse of the last value
`timescale 1ns/1ns
module seq_model
  import collect_pkg::*;
(
  input wire logic mclk,
  output logic [2:0] step_select_bus,
  output logic count_ram_write_n,
  output logic [15:0] count_ram_data_bus,
  output logic delay_parallel_load_n,
  output logic delay_count_enable
);
  // ****************
  // stimulus
  // ****************
  initial
  begin
    step_select_bus = 3'h0;
    count_ram_write_n = 1'b1;
    count_ram_data_bus = 16'h0000;
    delay_parallel_load_n = 1'b1;
    delay_count_enable = 1'b0;
  end
  task automatic wram(input logic [2:0] s, input logic [15:0] d);
    @(posedge mclk);
    step_select_bus <= s;
    count_ram_data_bus <= d;
    count_ram_write_n <= 1'b0;
    @(posedge mclk);
    count_ram_write_n <= 1'b1;
    count_ram_data_bus <= ~d;
  endtask
  task automatic load(input logic [2:0] s);
    @(posedge mclk);
    step_select_bus <= s;
    delay_parallel_load_n <= 1'b0;
    @(posedge mclk);
    delay_parallel_load_n <= 1'b1;
  endtask
  task automatic count(input int n);
    @(posedge mclk);
    delay_count_enable <= 1'b1;
    repeat (n) @(posedge mclk);
    delay_count_enable <= 1'b0;
  endtask
endmodule

// ---- state_collection_and_delay_counters_tb.sv ----
// Purpose: self-checking bench for the collection and delay counters
// Assumes: wr, rd and run start on a rising edge and end on a falling one; seq_model tasks end on a rising one
// Notes: status reads as terminal, halt, wrap in bits 2..0
`timescale 1ns/1ns
module state_collection_and_delay_counters_tb;
  import collect_pkg::*;
  logic mclk, rst_n, reg_wr, reg_rd, load_address_n, read_addr_en_n, trace, seq_done, output_float_ctrl;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, count_ram_data_bus;
  logic [9:0] proc_address, proc_data_o, acq_mem_address;
  logic [2:0] step_select_bus;
  logic proc_data_oe, count_ram_write_n, delay_parallel_load_n, delay_count_enable, delay_terminal_n_o;
  logic delay_terminal_n_oe, sample_write, wrap_clock_gate_n, translator_clock_gate_n, halt_n;
  logic main_mem_select, aux_mem_select;
  int miscompares, n_compared;
  logic [3:0] row_addr [4] = '{CTRL_ADDR, STATUS_ADDR, ADDR_COUNT_ADDR, 4'h5};
  logic [15:0] row_data [4] = '{16'h0006, 16'h0006, 16'h0017, 16'h0000};
  collect_counters dut_u (.*);
  seq_model seq_u (.*);
  // ****************
  // tasks
  // ****************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    settle(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    settle(1);
    check("reg_rdata", exp, reg_rdata);
  endtask
  task automatic run(input int n);
    @(posedge mclk);
    trace <= 1'b1;
    repeat (n) @(posedge mclk);
    trace <= 1'b0;
    settle(1);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict;
  end
  // ****************
  // sequence
  // ****************
  initial
  begin
    {rst_n, reg_wr, reg_rd, trace, seq_done, output_float_ctrl} = 6'h00;
    {load_address_n, read_addr_en_n} = 2'h3;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    proc_address = 10'h000;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    settle(3);
    check("acq_mem_address", 16'h0017, 16'(acq_mem_address));
    for (int i = 0; i < 4; i++)
      rd(row_addr[i], row_data[i]);
    check("main_mem_select", 16'h0001, 16'(main_mem_select));
    run(5);
    rd(ADDR_COUNT_ADDR, 16'h001C);
    @(posedge mclk);
    read_addr_en_n <= 1'b0;
    settle(2);
    check("proc_data_o", 16'h001C, 16'(proc_data_o));
    check("proc_data_oe", 16'h0001, 16'(proc_data_oe));
    @(posedge mclk);
    read_addr_en_n <= 1'b1;
    load_address_n <= 1'b0;
    proc_address <= 10'h2AB;
    trace <= 1'b1;
    settle(2);
    check("acq_mem_address", 16'h02AB, 16'(acq_mem_address));
    @(posedge mclk);
    load_address_n <= 1'b1;
    trace <= 1'b0;
    settle(3);
    check("acq_mem_address", 16'h001C, 16'(acq_mem_address));
    wr(CTRL_ADDR, 16'h000F);
    run(999);
    rd(STATUS_ADDR, 16'h0006);
    run(1);
    rd(STATUS_ADDR, 16'h0005);
    rd(ADDR_COUNT_ADDR, 16'h0017);
    check("translator_clock_gate_n", 16'h0000, 16'(translator_clock_gate_n));
    check("wrap_clock_gate_n", 16'h0000, 16'(wrap_clock_gate_n));
    wr(CTRL_ADDR, 16'h000E);
    run(1003);
    rd(STATUS_ADDR, 16'h0007);
    rd(ADDR_COUNT_ADDR, 16'h0017);
    wr(CTRL_ADDR, 16'h0008);
    run(3);
    rd(ADDR_COUNT_ADDR, 16'h0017);
    check("aux_mem_select", 16'h0001, 16'(aux_mem_select));
    check("main_mem_select", 16'h0000, 16'(main_mem_select));
    wr(CTRL_ADDR, 16'h000E);
    @(posedge mclk);
    seq_done <= 1'b1;
    @(posedge mclk);
    seq_done <= 1'b0;
    run(4);
    rd(STATUS_ADDR, 16'h0004);
    check("halt_n", 16'h0000, 16'(halt_n));
    rd(ADDR_COUNT_ADDR, 16'h0017);
    seq_u.wram(3'h2, 16'h0008);
    seq_u.wram(3'h5, 16'h0009);
    seq_u.wram(3'h3, 16'h1008);
    seq_u.load(3'h5);
    settle(1);
    check("delay_terminal_n_o", 16'h0000, 16'(delay_terminal_n_o));
    seq_u.load(3'h2);
    settle(3);
    check("delay_terminal_n_o", 16'h0001, 16'(delay_terminal_n_o));
    seq_u.count(1);
    settle(1);
    check("delay_terminal_n_o", 16'h0000, 16'(delay_terminal_n_o));
    seq_u.load(3'h3);
    seq_u.count(1);
    settle(1);
    check("delay_terminal_n_o", 16'h0001, 16'(delay_terminal_n_o));
    seq_u.wram(3'h6, 16'h0109);
    seq_u.load(3'h6);
    seq_u.count(99);
    settle(1);
    check("delay_terminal_n_o", 16'h0001, 16'(delay_terminal_n_o));
    seq_u.count(1);
    settle(1);
    check("delay_terminal_n_o", 16'h0000, 16'(delay_terminal_n_o));
    @(posedge mclk);
    output_float_ctrl <= 1'b1;
    settle(1);
    check("delay_terminal_n_oe", 16'h0000, 16'(delay_terminal_n_oe));
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    settle(1);
    rd(CTRL_ADDR, 16'h0006);
    rd(STATUS_ADDR, 16'h0006);
    check("acq_mem_address", 16'h0017, 16'(acq_mem_address));
    give_verdict;
  end
endmodule
bind collect_counters collect_counters_properties chk_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .load_address_n(load_address_n), .proc_address(proc_address),
  .acq_mem_address(acq_mem_address), .read_addr_en_n(read_addr_en_n), .proc_data_oe(proc_data_oe),
  .output_float_ctrl(output_float_ctrl), .delay_terminal_n_oe(delay_terminal_n_oe), .trace(trace),
  .seq_done(seq_done), .halt_n(halt_n), .sample_write(sample_write), .wrap_clock_gate_n(wrap_clock_gate_n),
  .translator_clock_gate_n(translator_clock_gate_n));
